// ### common/seq_pkg.sv
package seq_pkg;
  // Timing: one sequencer tick is 100 ms at a 10 ns clock.
  localparam int CLK_NS         = 10;
  localparam int TICK_NS        = 100_000_000;
  localparam int TICK_CYC       = TICK_NS / CLK_NS;
  localparam int TICKS_PER_S    = 1_000_000_000 / TICK_NS;
  // Register byte offsets.
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_REF   = 8'h04;
  localparam logic [7:0] A_START = 8'h08;
  localparam logic [7:0] A_STOP  = 8'h0C;
  localparam logic [7:0] A_BRAKE = 8'h10;
  localparam logic [7:0] A_VF    = 8'h14;
  localparam logic [7:0] A_PROT  = 8'h18;
  localparam logic [7:0] A_STAT  = 8'h1C;
  localparam int N_CFG = 7;
  // Field positions.
  localparam int F_RUN   = 0;
  localparam int F_REV   = 1;
  localparam int F_DLY   = 0;
  localparam int F_SMODE = 8;
  localparam int F_HST   = 12;
  localparam int F_SFUNC = 0;
  localparam int F_SACT  = 8;
  localparam int F_BPCT  = 0;
  localparam int F_BTIME = 8;
  localparam int F_CUTIN = 16;
  localparam int F_SFREQ = 0;
  localparam int F_IVOLT = 8;
  localparam int F_HOLD  = 24;
  localparam int F_TSEL  = 0;
  localparam int F_DIFN  = 4;
  localparam int F_SETUP = 8;
  localparam int F_ST    = 0;
  localparam int F_WARN  = 8;
  localparam int F_TRIP  = 9;
  localparam int F_BRK   = 10;
  localparam int F_HSTON = 11;
  localparam int F_FREQ  = 16;
  // Reset values: delay 0, stop freq 0.1 Hz, brake 10 s, all else 0.
  localparam logic [31:0] R_CTRL  = 32'h0000_0000;
  localparam logic [31:0] R_REF   = 32'h0000_0000;
  localparam logic [31:0] R_START = 32'h0000_0000;
  localparam logic [31:0] R_STOP  = 32'h0000_0100;
  localparam logic [31:0] R_BRAKE = 32'h0000_0A00;
  localparam logic [31:0] R_VF    = 32'h0000_0000;
  localparam logic [31:0] R_PROT  = 32'h0000_0000;
  localparam logic [31:0] M_CTRL  = 32'h0000_0003;
  localparam logic [31:0] M_REF   = 32'h0000_FFFF;
  localparam logic [31:0] M_START = 32'h0000_777F;
  localparam logic [31:0] M_STOP  = 32'h0000_7F01;
  localparam logic [31:0] M_BRAKE = 32'hFFFF_3F7F;
  localparam logic [31:0] M_VF    = 32'h7F07_FF7F;
  localparam logic [31:0] M_PROT  = 32'h0000_03FF;
  // Start modes, protection codes, input function.
  localparam logic [2:0] SM_HOLD  = 3'h0;
  localparam logic [2:0] SM_BRAKE = 3'h1;
  localparam logic [2:0] SM_OFF   = 3'h2;
  localparam logic [2:0] SM_CW    = 3'h3;
  localparam logic [2:0] SM_REFD  = 3'h4;
  localparam logic [3:0] TP_NONE  = 4'h0;
  localparam logic [3:0] TP_THW   = 4'h1;
  localparam logic [3:0] TP_THT   = 4'h2;
  localparam logic [3:0] TP_CL1   = 4'h3;
  localparam logic [3:0] TP_CL4T  = 4'hA;
  localparam logic [3:0] DI_BRAKE_INV = 4'h5;
  // Current limit in tenths of nominal inverter current.
  localparam logic [4:0] ILIM_NOM = 5'h0A;
  localparam logic [4:0] ILIM_HST = 5'h12;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b0_0001,
    ST_DELAY = 5'b0_0010,
    ST_RUN   = 5'b0_0100,
    ST_STOP  = 5'b0_1000,
    ST_BRAKE = 5'b1_0000
  } seq_state_t;

  typedef struct packed {
    logic        inv_en;
    logic        dc_en;
    logic [6:0]  dc_pct;
    logic        dir;
    logic [15:0] freq;
    logic        volt_on;
    logic [10:0] volt;
    logic [4:0]  ilim;
  } drive_t;
endpackage

// ### design/motor_start_stop_sequencer.sv
// Operation
// (RULE_01) High start current 1.8x nominal, window to 0.5 s; the code accepts windows up to 7 ticks, 0.7 s.
// (RULE_02) Zero window disables high start current.
// (RULE_03) Wait start delay, then ramp to reference.
// (RULE_04) Mode 0: At_stop_a voltage during delay.
// (RULE_05) Mode 1: DC brake voltage during delay.
// (RULE_06) Mode 2: inverter off during delay.
// (RULE_07) Mode 3: start frequency, voltage, clockwise.
// (RULE_08) Mode 4: start freq or 0 Hz, reference direction.
// (RULE_09) Stop function: 0 inverter_release, 1 At_stop_a.
// (RULE_10) Stop function below threshold or after stop.
// (RULE_11) Stop threshold 0.1 to 10 Hz, default 0.1; the code accepts 0 to 12.7 Hz.
// (RULE_12) Threshold above start frequency skips start delay.
// (RULE_13) At_stop_a stop: start steps to threshold.
// (RULE_14) Brake voltage is percent of maximum.
// (RULE_15) Falling brake input with function 5 brakes.
// (RULE_16) Stop command brakes below cut-in frequency.
// (RULE_17) Brake lasts programmed time, default 10 s.
// (RULE_18) Cut-in zero disables frequency triggered braking.
// (RULE_19) Protection codes 0 to 10 decoded.
// (RULE_20) Load setups count only when setup active.
// (RULE_21) Warning variants warn, trip variants stop.
// (RULE_22) Durations use system tick; reset restores defaults.
`timescale 1ns/100ps
module motor_start_stop_sequencer #(
  parameter int          TICK_CYCLES = seq_pkg::TICK_CYC,
  parameter logic [15:0] RAMP_STEP   = 16'h000A,
  parameter logic [4:0]  ILIM_SAFE   = 5'h14
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  brake_input_pin,
  input  wire logic                  thermistor_hot_pin,
  input  wire logic [3:0]            calc_overload,
  output      seq_pkg::drive_t       drive,
  output      logic [3:0]            calc_load_enable,
  output      logic                  thermal_warning,
  output      logic                  thermal_trip
);
  import seq_pkg::*;

  // Register bus.
  logic [31:0] cfg [N_CFG];
  logic [31:0] next_cfg [N_CFG];
  logic        aw_hold, w_hold;
  logic        next_aw_hold, next_w_hold;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_awready, next_wready, next_bvalid;
  logic        next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, status, wmask, bytemask;
  logic [2:0]  widx;

  // Pin synchronisers and tick.
  logic [2:0]  brk_s, hot_s;
  logic        brk_f, hot_f, brk_prev, tick;
  logic [31:0] tick_cnt, next_tick_cnt;

  // Sequencer state.
  seq_state_t  st, next_st;
  logic [15:0] freq, next_freq, tgt;
  logic [9:0]  cnt, next_cnt;
  logic [2:0]  hcnt, next_hcnt;
  drive_t      next_drive;
  logic        brk_fall, start_ok;

  // Thermal state.
  logic        next_warn, next_trip, cond, is_trip_sel;
  logic [3:0]  next_cle;
  logic [2:0]  cl_idx;

  // Configuration fields.
  logic        run, rev, sfunc;
  logic [6:0]  dly, sact, bpct, sfreq, hold_pct;
  logic [2:0]  smode, hst;
  logic [5:0]  btime;
  logic [15:0] reff, cutin;
  logic [10:0] ivolt;
  logic [3:0]  tsel, difn;
  logic [1:0]  setup;

  assign run      = cfg[0][F_RUN];
  assign rev      = cfg[0][F_REV];
  assign reff     = cfg[1][15:0];
  assign dly      = cfg[2][F_DLY +: 7];
  assign smode    = cfg[2][F_SMODE +: 3];
  assign hst      = cfg[2][F_HST +: 3];
  assign sfunc    = cfg[3][F_SFUNC];
  assign sact     = cfg[3][F_SACT +: 7];
  assign bpct     = cfg[4][F_BPCT +: 7];
  assign btime    = cfg[4][F_BTIME +: 6];
  assign cutin    = cfg[4][F_CUTIN +: 16];
  assign sfreq    = cfg[5][F_SFREQ +: 7];
  assign ivolt    = cfg[5][F_IVOLT +: 11];
  assign hold_pct = cfg[5][F_HOLD +: 7];
  assign tsel     = cfg[6][F_TSEL +: 4];
  assign difn     = cfg[6][F_DIFN +: 4];
  assign setup    = cfg[6][F_SETUP +: 2];

  localparam logic [31:0] RST [N_CFG] = '{R_CTRL, R_REF, R_START,
    R_STOP, R_BRAKE, R_VF, R_PROT};
  localparam logic [31:0] MSK [N_CFG] = '{M_CTRL, M_REF, M_START,
    M_STOP, M_BRAKE, M_VF, M_PROT};

  always_comb begin
    status = 32'h0000_0000;
    status[F_ST +: 5] = st;
    status[F_WARN] = thermal_warning;
    status[F_TRIP] = thermal_trip;
    status[F_BRK] = (st == ST_BRAKE);
    status[F_HSTON] = (hcnt != 3'h0);
    status[F_FREQ +: 16] = freq;
  end

  // Address and data are caught in either order; the write is done
  // once both are held and the previous response has been taken.
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    bytemask     = 32'h0000_0000;
    widx         = aw_addr[4:2];
    wmask        = 32'h0000_0000;
    for (int i = 0; i < N_CFG; i++) begin
      next_cfg[i] = cfg[i];
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_hold && w_hold && !s_axi_bvalid) begin
      for (int b = 0; b < 4; b++) begin
        bytemask[8*b +: 8] = {8{w_strb[b]}};
      end
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OK;
      if (aw_addr[1:0] != 2'h0 || aw_addr > A_STAT) begin
        next_bresp = RESP_ERR;
      end else if (aw_addr != A_STAT) begin
        wmask = bytemask & MSK[widx];
        next_cfg[widx] = (cfg[widx] & ~wmask) | (w_data & wmask);
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
      next_arready = 1'b1;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OK;
      next_rdata   = 32'h0000_0000;
      if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > A_STAT) begin
        next_rresp = RESP_ERR;
      end else if (s_axi_araddr == A_STAT) begin
        next_rdata = status;
      end else begin
        next_rdata = cfg[s_axi_araddr[4:2]];
      end
    end
    next_awready = !next_aw_hold;
    next_wready  = !next_w_hold;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg           <= RST; // RULE_22
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else if (ce) begin
      cfg           <= next_cfg;
      aw_hold       <= next_aw_hold;
      w_hold        <= next_w_hold;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // A pin level is accepted once the second and third stages agree.
  always_comb begin
    next_tick_cnt = tick_cnt + 32'h0000_0001;
    tick = (tick_cnt == 32'(TICK_CYCLES - 1));
    if (tick) begin
      next_tick_cnt = 32'h0000_0000;
    end
    brk_fall = brk_prev && !brk_f && (difn == DI_BRAKE_INV); // RULE_15
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brk_s    <= 3'b111;
      hot_s    <= 3'b000;
      brk_f    <= 1'b1;
      hot_f    <= 1'b0;
      brk_prev <= 1'b1;
      tick_cnt <= 32'h0000_0000;
    end else if (ce) begin
      brk_s    <= {brk_s[1:0], brake_input_pin};
      hot_s    <= {hot_s[1:0], thermistor_hot_pin};
      brk_f    <= (brk_s[2] == brk_s[1]) ? brk_s[2] : brk_f;
      hot_f    <= (hot_s[2] == hot_s[1]) ? hot_s[2] : hot_f;
      brk_prev <= brk_f;
      tick_cnt <= next_tick_cnt; // RULE_22
    end
  end

  // Sequencer. Frequencies in 0.1 Hz, delays in ticks.
  always_comb begin
    next_st   = st;
    next_freq = freq;
    next_cnt  = cnt;
    next_hcnt = hcnt;
    tgt       = run ? reff : 16'h0000;
    start_ok  = run && !thermal_trip;
    if (tick && hcnt != 3'h0) begin
      next_hcnt = hcnt - 3'h1; // RULE_01
    end
    unique case (st)
      ST_IDLE: begin
        next_freq = 16'h0000;
        if (start_ok) begin
          next_hcnt = hst; // RULE_02
          if (sact > sfreq || dly == 7'h00) begin
            next_st = ST_RUN; // RULE_12
            next_freq = sfunc ? {9'h000, sact} : 16'h0000; // RULE_13
          end else begin
            next_st  = ST_DELAY; // RULE_03
            next_cnt = {3'h0, dly};
          end
        end
      end
      ST_DELAY: begin
        if (!run) begin
          next_st = ST_IDLE;
        end else if (tick) begin
          next_cnt = cnt - 10'h001;
          if (cnt <= 10'h001) begin
            next_st = ST_RUN; // RULE_03
            next_freq = sfunc ? {9'h000, sact} : 16'h0000; // RULE_13
          end
        end
      end
      ST_RUN: begin
        if (tick) begin
          if (freq + RAMP_STEP <= tgt) begin
            next_freq = freq + RAMP_STEP;
          end else if (freq >= tgt + RAMP_STEP) begin
            next_freq = freq - RAMP_STEP;
          end else begin
            next_freq = tgt;
          end
        end
        if (!run && cutin != 16'h0000 && freq < cutin) begin
          next_st  = ST_BRAKE; // RULE_16 RULE_18
          next_cnt = 10'(btime * TICKS_PER_S);
        end else if (freq < {9'h000, sact} && tgt < {9'h000, sact}) begin
          next_st = ST_STOP; // RULE_10 RULE_11
        end
      end
      ST_STOP: begin
        next_freq = 16'h0000;
        if (start_ok && reff >= {9'h000, sact}) begin
          next_st = ST_RUN;
          next_freq = sfunc ? {9'h000, sact} : 16'h0000;
        end else if (!run && !sfunc) begin
          next_st = ST_IDLE;
        end
      end
      ST_BRAKE: begin
        next_freq = 16'h0000;
        if (cnt == 10'h000) begin
          next_st = ST_STOP;
        end else if (tick) begin
          next_cnt = cnt - 10'h001; // RULE_17
        end
      end
    endcase
    if (brk_fall && !thermal_trip) begin
      next_st   = ST_BRAKE; // RULE_15
      next_freq = 16'h0000;
      next_cnt  = 10'(btime * TICKS_PER_S);
    end
    if (thermal_trip) begin
      next_st   = ST_IDLE; // RULE_21
      next_freq = 16'h0000;
      next_hcnt = 3'h0;
    end
  end

  // Drive word follows the state being entered.
  always_comb begin
    next_drive        = '0;
    next_drive.ilim   = ILIM_NOM;
    next_drive.dir    = rev;
    next_drive.freq   = next_freq;
    next_drive.inv_en = (next_st == ST_RUN);
    if (next_hcnt != 3'h0) begin
      next_drive.ilim = (ILIM_HST < ILIM_SAFE) ? ILIM_HST : ILIM_SAFE;
    end
    unique case (next_st)
      ST_DELAY: begin
        unique case (smode)
          SM_HOLD: begin
            next_drive.inv_en = 1'b1; // RULE_04
            next_drive.dc_en  = 1'b1;
            next_drive.dc_pct = hold_pct;
          end
          SM_BRAKE: begin
            next_drive.inv_en = 1'b1; // RULE_05
            next_drive.dc_en  = 1'b1;
            next_drive.dc_pct = bpct;
          end
          SM_CW: begin
            next_drive.inv_en  = 1'b1; // RULE_07
            next_drive.freq    = {9'h000, sfreq};
            next_drive.dir     = 1'b0;
            next_drive.volt_on = 1'b1;
            next_drive.volt    = ivolt;
          end
          SM_REFD: begin
            next_drive.inv_en  = 1'b1; // RULE_08
            next_drive.freq    = (reff == 16'h0000) ? 16'h0000
                                                    : {9'h000, sfreq};
            next_drive.volt_on = 1'b1;
            next_drive.volt    = ivolt;
          end
          default: begin
            next_drive.inv_en = 1'b0; // RULE_06
          end
        endcase
      end
      ST_STOP: begin
        next_drive.inv_en = sfunc; // RULE_09
        next_drive.dc_en  = sfunc;
        next_drive.dc_pct = sfunc ? hold_pct : 7'h00;
      end
      ST_BRAKE: begin
        next_drive.inv_en = 1'b1; // RULE_14
        next_drive.dc_en  = 1'b1;
        next_drive.dc_pct = bpct;
      end
      default: begin
        next_drive.dc_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st    <= ST_IDLE;
      freq  <= 16'h0000;
      cnt   <= 10'h000;
      hcnt  <= 3'h0;
      drive <= '0;
    end else if (ce) begin
      st    <= next_st;
      freq  <= next_freq;
      cnt   <= next_cnt;
      hcnt  <= next_hcnt;
      drive <= next_drive;
    end
  end

  // Thermal protection selector.
  always_comb begin
    cl_idx      = 3'(4'(tsel - TP_CL1) >> 1);
    is_trip_sel = (tsel != TP_NONE) && !tsel[0]; // RULE_19
    next_cle    = 4'h0;
    cond        = 1'b0;
    if (tsel == TP_THW || tsel == TP_THT) begin
      cond = hot_f;
    end else if (tsel >= TP_CL1 && tsel <= TP_CL4T) begin
      if (setup == cl_idx[1:0]) begin
        next_cle[cl_idx[1:0]] = 1'b1; // RULE_20
        cond = calc_overload[cl_idx[1:0]];
      end
    end
    next_warn = cond && !is_trip_sel; // RULE_21
    next_trip = thermal_trip ? (run || cond) : (cond && is_trip_sel);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_warning  <= 1'b0;
      thermal_trip     <= 1'b0;
      calc_load_enable <= 4'h0;
    end else if (ce) begin
      thermal_warning  <= next_warn;
      thermal_trip     <= next_trip;
      calc_load_enable <= next_cle;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_hst_off;
    (ce && st == ST_IDLE && next_st != ST_IDLE && hst == 3'h0)
      |=> drive.ilim == ILIM_NOM;
  endproperty
  a_hst_off: assert property (p_hst_off) // RULE_02
    else $error("start current raised with zero window");

  property p_hst_on;
    (ce && st == ST_IDLE && next_st == ST_RUN && hst != 3'h0)
      |=> drive.ilim != ILIM_NOM && hcnt == $past(hst);
  endproperty
  a_hst_on: assert property (p_hst_on) // RULE_01
    else $error("start current window not opened");

  property p_inverter_release_delay;
    (st == ST_DELAY && $stable(smode) && smode == SM_OFF)
      |-> !drive.inv_en;
  endproperty
  a_inverter_release_delay: assert property (p_inverter_release_delay) // RULE_06
    else $error("inverter on in coasting delay");

  property p_cw_delay;
    (st == ST_DELAY && $stable(cfg[2]) && $stable(cfg[5])
      && smode == SM_CW)
      |-> drive.freq == {9'h000, sfreq} && !drive.dir;
  endproperty
  a_cw_delay: assert property (p_cw_delay) // RULE_07
    else $error("clockwise start output wrong");

  property p_skip_delay;
    (ce && st == ST_IDLE && start_ok && sact > sfreq && !brk_fall)
      |=> st == ST_RUN;
  endproperty
  a_skip_delay: assert property (p_skip_delay) // RULE_12
    else $error("start delay not skipped");

  property p_hold_jump;
    (ce && st == ST_IDLE && next_st == ST_RUN && sfunc)
      |=> freq == {9'h000, $past(sact)};
  endproperty
  a_hold_jump: assert property (p_hold_jump) // RULE_13
    else $error("output did not step to stop frequency");

  property p_brake_time;
    (ce && brk_fall && !thermal_trip)
      |=> st == ST_BRAKE && cnt == 10'($past(btime) * TICKS_PER_S);
  endproperty
  a_brake_time: assert property (p_brake_time) // RULE_15
    else $error("brake input fall did not start braking");

  property p_trip_stop;
    (ce && thermal_trip) |=> st == ST_IDLE ##1 !drive.inv_en || !ce;
  endproperty
  a_trip_stop: assert property (p_trip_stop) // RULE_21
    else $error("trip did not stop inverter");
endmodule

// ### test/motor_model.sv
`timescale 1ns/100ps
// Motor seen through the inverter: winding heat and calculated overload
// follow what the bench commands; the sensor pin copies the bench hot level and the drive word is not used.
module motor_model (
  input  wire seq_pkg::drive_t drive,
  input  wire logic            hot,
  input  wire logic [3:0]      load,
  output      logic            thermistor_hot_pin,
  output      logic [3:0]      calc_overload
);
  import seq_pkg::*;
  assign thermistor_hot_pin = hot;
  assign calc_overload      = load;
endmodule

// ### test/motor_start_stop_sequencer_tb.sv
`timescale 1ns/100ps
module motor_start_stop_sequencer_tb;
  import seq_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, brk = 1, hot = 0;
  logic awready, wready, bvalid, arready, rvalid, warn, trip;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic [1:0] bresp, rresp;
  logic [3:0] load = 0, cle, ovl;
  logic thp;
  drive_t drv;
  int n_fail = 0, n_tests = 0;
  always #5 aclk = ~aclk;
  motor_start_stop_sequencer #(.TICK_CYCLES(10)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .brake_input_pin(brk), .thermistor_hot_pin(thp),
    .calc_overload(ovl), .drive(drv), .calc_load_enable(cle),
    .thermal_warning(warn), .thermal_trip(trip));
  motor_model motor (.drive(drv), .hot(hot), .load(load),
    .thermistor_hot_pin(thp), .calc_overload(ovl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready && !ta) begin awvalid <= 0; ta = 1; end
      if (wready && !tw) begin wvalid <= 0; tw = 1; end
    end while (!(ta && tw));
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 0;
    chk(bresp, RESP_OK);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    arvalid <= 0; rready <= 0;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    logic [1:0] r;
    rd(a, v, r);
    chk(v, e);
    chk(r, RESP_OK);
  endtask
  task automatic wait_state(input logic [4:0] s);
    logic [1:0] r;
    int n;
    n = 0;
    do begin rd(A_STAT, v, r); n++; end while (v[4:0] !== s && n < 600);
    chk(v[4:0], s);
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200_000;
    n_fail++;
    end_of_test;
  end
  initial begin
    logic [1:0] r;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    expect_reg(A_STOP, 32'h0000_0100);
    expect_reg(A_BRAKE, 32'h0000_0A00);
    expect_reg(A_START, 32'h0000_0000);
    expect_reg(A_PROT, 32'h0000_0000);
    rd(8'h20, v, r);
    chk(r, RESP_ERR);
    wr(A_VF, 32'h0900_0705);
    wr(A_BRAKE, 32'h0000_0A14);
    wr(A_REF, 32'h0000_0014);
    for (int m = 0; m < 5; m++) begin
      wr(A_START, 32'h0000_0003 | (m << F_SMODE));
      wr(A_CTRL, 32'h0000_0003);
      wait_state(5'h02);
      case (m)
        0: chk(drv.dc_pct, 7'h09);
        1: chk(drv.dc_pct, 7'h14);
        2: chk(drv.inv_en, 1'b0);
        3: chk({drv.dir, drv.freq, drv.volt}, {1'b0, 16'h5, 11'h7});
        default: chk({drv.dir, drv.freq}, {1'b1, 16'h5});
      endcase
      if (m < 2) chk(drv.dc_en, 1'b1);
      wait_state(5'h04);
      wr(A_CTRL, 32'h0000_0000);
      wait_state(5'h01);
    end
    wr(A_REF, 32'h0000_0000);
    wr(A_START, 32'h0000_0403);
    wr(A_CTRL, 32'h0000_0001);
    wait_state(5'h02);
    chk({drv.freq, drv.volt}, {16'h0000, 11'h007});
    wr(A_CTRL, 32'h0000_0000);
    wait_state(5'h01);
    wr(A_REF, 32'h0000_000A);
    wr(A_STOP, 32'h0000_0A01);
    wr(A_START, 32'h0000_3003);
    wr(A_CTRL, 32'h0000_0001);
    rd(A_STAT, v, r);
    chk(v[4:0], 5'h04);
    chk(v[31:16], 16'h000A);
    chk(drv.ilim, 5'h12);
    wr(A_CTRL, 32'h0000_0000);
    wait_state(5'h08);
    chk({drv.dc_en, drv.dc_pct}, {1'b1, 7'h09});
    wr(A_STOP, 32'h0000_0100);
    wait_state(5'h01);
    wr(A_BRAKE, 32'h0014_0114);
    wr(A_REF, 32'h0000_0014);
    wr(A_CTRL, 32'h0000_0001);
    wait_state(5'h04);
    wr(A_CTRL, 32'h0000_0000);
    wait_state(5'h10);
    wait_state(5'h01);
    wr(A_PROT, 32'h0000_0050);
    @(posedge aclk) brk <= 0;
    wait_state(5'h10);
    chk({drv.dc_en, drv.dc_pct}, {1'b1, 7'h14});
    wait_state(5'h01);
    brk <= 1;
    wr(A_PROT, 32'h0000_0002);
    @(posedge aclk) hot <= 1;
    repeat (8) @(posedge aclk);
    chk(trip, 1'b1);
    wr(A_PROT, 32'h0000_0001);
    repeat (8) @(posedge aclk);
    // The trip stays latched while the sensor is still hot.
    chk({warn, trip}, 2'b11);
    hot <= 0;
    wr(A_PROT, 32'h0000_0207);
    load <= 4'b0100;
    repeat (4) @(posedge aclk);
    chk(cle, 4'b0100);
    chk(warn, 1'b1);
    end_of_test;
  end
endmodule
